/* File: core/ee_pkg.sv */
/*
 * constants, command codes and state type of the serial byte memory front end.
 * assumes a 20 MHz core clock; shared by the core module and the testbench.
 */
package ee_pkg;
   // core clock and self-timed write cycle
   localparam int CLK_PERIOD_NS = 50;
   localparam int T_WRITE_NS = 3000000;
   localparam int WRITE_CYC = T_WRITE_NS / CLK_PERIOD_NS;
   // storage geometry
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_COUNT = 1024;
   localparam int MEM_BYTES = PAGE_BYTES * PAGE_COUNT;
   localparam int ADDR_W = 18;
   localparam logic [1:0] ADDR_LAST = 2'h2;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // id page sub-address bit that selects lock status / lock operation
   localparam int LOCK_SEL_BIT = 10;
   // instruction codes
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_WRSR = 8'h01;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_RDID = 8'h83;
   localparam logic [7:0] OP_WRID = 8'h82;
   localparam logic [7:0] OP_RDUID = 8'h4B;
   // status byte field positions
   localparam int SR_BUSY = 0;
   localparam int SR_WEL = 1;
   localparam int SR_BP_LO = 2;
   localparam int SR_SRWD = 7;
   // reset values
   localparam logic [1:0] BP_RST = 2'h0;
   // unique identifier; value arbitrary
   localparam logic [127:0] UID_VAL = 128'h0123456789ABCDEF_FEDCBA9876543210;
   // protocol states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_CMD = 5'h02,
      ST_ADDR = 5'h04,
      ST_DATA = 5'h08,
      ST_WAIT = 5'h10
   } ee_state_e;
endpackage : ee_pkg

/* File: core/ee_spi_eeprom.sv */
/*
 * serial-bus slave front end of a byte memory with id page, lock and unique id.
 * assumes the link pins are asynchronous to i_core_clk and far slower than it.
 */
// Function
// R1: only clock modes 0 and 3; data sampled on the rising clock edge.
// R2: capture command, address and write data on each rising serial clock edge.
// R3: change serial output after each falling serial clock edge.
// R4: select high deselects and floats output; select low activates.
// R5: deselected device enters standby unless a write cycle still runs.
// R6: no command accepted before a falling select edge after power-up.
// R7: write-protect input asserted freezes the protected area size; here only while status bit SRWD is also set.
// R8: master holds write-protect steady during every write instruction.
// R9: pause floats output, ignores clock and data, keeps transfer position.
// R10: master keeps select low to enter pause.
// R11: byte writes and page writes of up to 256 bytes.
// R12: writes finish in a self-timed cycle of at most 3 ms.
// R13: block protection of a quarter, half or whole main array.
// R14: main array is 1024 pages of 256 bytes, one linear space.
// R15: extra 256-byte id page, permanently read-only once locked; here the lock bit is cleared by reset.
// R16: read-only 128-bit identifier readable only by its own command.
// R17: all bytes move most significant bit first.
// R18: unknown command: ignore the rest until select goes high.
// R19: every modifying command needs write_enable_latch set beforehand.
// R20: pause begins only while serial clock is low; deferred otherwise.
// R21: modifying commands are rejected while a write cycle runs.
`timescale 1ns/1ns
module ee_spi_eeprom #(
   parameter int P_WRITE_CYC = ee_pkg::WRITE_CYC
) (
   // core
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // serial link pins
   input wire logic i_spi_clk,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_miso,
   output logic o_miso_oe,
   // state
   output logic o_standby,
   output logic o_busy
);
   logic [4:0] sy1_r, sy2_r;
   logic clk_d_r, cs_d_r;
   logic clk_s, cs_s, mosi_s, hold_s, wp_s;
   logic clk_rise, clk_fall, cs_fall, cs_rise, rise_e, fall_e, wr_byte_e, rd_op;
   ee_pkg::ee_state_e st_r, st_nxt;
   logic [7:0] op_r, op_nxt, sh_r, sh_nxt, tx_r, tx_nxt, srd_r, srd_nxt, cp_r, cp_nxt, byte_v, status_v;
   logic [2:0] bit_r, bit_nxt;
   logic [1:0] acnt_r, acnt_nxt, bp_r, bp_nxt;
   logic [17:0] addr_r, addr_nxt, na_v;
   logic [9:0] page_r, page_nxt;
   logic [31:0] tmr_r, tmr_nxt;
   logic [255:0] mask_r, mask_nxt;
   logic q_r, q_nxt, wel_r, wel_nxt, srwd_r, srwd_nxt, lock_r, lock_nxt, got_r, got_nxt;
   logic busy_r, busy_nxt, cpon_r, cpon_nxt, tgt_r, tgt_nxt, hold_r, hold_nxt, prot_v;
   logic [7:0] mem [0:ee_pkg::MEM_BYTES-1];
   logic [7:0] idpg [0:ee_pkg::PAGE_BYTES-1];
   logic [7:0] pg_buf [0:ee_pkg::PAGE_BYTES-1];

   // two-flop synchronisers; only the second stage is read
   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         // select starts low: one held low through reset gives no false fall
         sy1_r <= 5'h0A;
         sy2_r <= 5'h0A;
         clk_d_r <= 1'b0;
         cs_d_r <= 1'b0; // [R6]
      end else begin
         sy1_r <= {i_cs_n, i_hold_n, i_wp_n, i_mosi, i_spi_clk};
         sy2_r <= sy1_r;
         clk_d_r <= sy2_r[0];
         cs_d_r <= sy2_r[4];
      end
   end
   assign clk_s = sy2_r[0];
   assign mosi_s = sy2_r[1];
   assign wp_s = sy2_r[2];
   assign hold_s = sy2_r[3];
   assign cs_s = sy2_r[4];
   assign clk_rise = clk_s & ~clk_d_r;
   assign clk_fall = ~clk_s & clk_d_r;
   assign cs_fall = ~cs_s & cs_d_r; // [R6]
   assign cs_rise = cs_s & ~cs_d_r;
   assign rise_e = clk_rise & ~cs_s & ~hold_r; // [R1] [R2] [R9]
   assign fall_e = clk_fall & ~cs_s & ~hold_r; // [R9]
   assign byte_v = {sh_r[6:0], mosi_s}; // [R17]
   assign na_v = {addr_r[9:0], byte_v};
   assign rd_op = (op_r == ee_pkg::OP_READ) | (op_r == ee_pkg::OP_RDID) | (op_r == ee_pkg::OP_RDUID)
                  | (op_r == ee_pkg::OP_RDSR);
   assign wr_byte_e = rise_e & (bit_r == ee_pkg::BIT_LAST) & (st_r == ee_pkg::ST_DATA)
                      & ((op_r == ee_pkg::OP_WRITE) | (op_r == ee_pkg::OP_WRID));
   assign status_v = {srwd_r, 3'h0, bp_r, wel_r, busy_r};
   // quarter, half or whole array, counted from the top
   assign prot_v = (bp_r == 2'h3) | ((bp_r == 2'h2) & addr_r[17]) | ((bp_r == 2'h1) & (&addr_r[17:16])); // [R13]

   function automatic logic [7:0] rd_byte(input logic [7:0] op, input logic [17:0] a);
      logic [127:0] uid_v;
      uid_v = ee_pkg::UID_VAL >> {~a[3:0], 3'h0};
      case (op)
         ee_pkg::OP_READ: rd_byte = mem[a]; // [R14]
         ee_pkg::OP_RDID: rd_byte = a[ee_pkg::LOCK_SEL_BIT] ? {7'h00, lock_r} : idpg[a[7:0]];
         ee_pkg::OP_RDUID: rd_byte = uid_v[7:0]; // [R16]
         default: rd_byte = status_v;
      endcase
   endfunction : rd_byte

   always_comb begin
      st_nxt = st_r;
      op_nxt = op_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      acnt_nxt = acnt_r;
      addr_nxt = addr_r;
      page_nxt = page_r;
      tx_nxt = tx_r;
      q_nxt = q_r;
      wel_nxt = wel_r;
      bp_nxt = bp_r;
      srwd_nxt = srwd_r;
      lock_nxt = lock_r;
      got_nxt = got_r;
      srd_nxt = srd_r;
      busy_nxt = busy_r;
      tmr_nxt = tmr_r;
      cp_nxt = cp_r;
      cpon_nxt = cpon_r;
      tgt_nxt = tgt_r;
      mask_nxt = mask_r;
      hold_nxt = hold_r;
      // while selected, pause changes state only in a clock low phase; deselect ends it at once
      if (cs_s) begin
         hold_nxt = 1'b0;
      end else if (!clk_s) begin
         hold_nxt = ~hold_s; // [R20]
      end
      if (busy_r) begin
         if (tmr_r == 32'h0) begin
            busy_nxt = 1'b0;
         end else begin
            tmr_nxt = tmr_r - 32'h1; // [R12]
         end
      end
      if (cpon_r) begin
         cp_nxt = cp_r + 8'h01;
         if (cp_r == 8'hFF) begin
            cpon_nxt = 1'b0;
         end
      end
      if (cs_fall) begin
         st_nxt = ee_pkg::ST_CMD; // [R6]
         bit_nxt = 3'h0;
         acnt_nxt = 2'h0;
         got_nxt = 1'b0;
      end else if (cs_rise) begin
         // deselect during pause resets without committing
         if (st_r == ee_pkg::ST_DATA && got_r && bit_r == 3'h0 && !hold_r) begin
            busy_nxt = 1'b1;
            tmr_nxt = 32'(P_WRITE_CYC - 1); // [R12]
            wel_nxt = 1'b0;
            cp_nxt = 8'h00;
            page_nxt = addr_r[17:8];
            case (op_r)
               ee_pkg::OP_WRITE: begin
                  cpon_nxt = ~prot_v; // [R13]
                  tgt_nxt = 1'b0;
               end
               ee_pkg::OP_WRID: begin
                  if (addr_r[ee_pkg::LOCK_SEL_BIT]) begin
                     lock_nxt = 1'b1; // [R15]
                  end else begin
                     cpon_nxt = ~lock_r; // [R15]
                     tgt_nxt = 1'b1;
                  end
               end
               default: begin
                  bp_nxt = srd_r[ee_pkg::SR_BP_LO +: 2];
                  srwd_nxt = srd_r[ee_pkg::SR_SRWD];
               end
            endcase
         end
         st_nxt = ee_pkg::ST_IDLE; // [R4]
      end else if (rise_e) begin
         sh_nxt = byte_v; // [R2]
         bit_nxt = bit_r + 3'h1;
         if (bit_r == ee_pkg::BIT_LAST) begin
            case (st_r)
               ee_pkg::ST_CMD: begin
                  op_nxt = byte_v;
                  case (byte_v)
                     ee_pkg::OP_WREN: begin
                        wel_nxt = wel_r | ~busy_r;
                        st_nxt = ee_pkg::ST_WAIT;
                     end
                     ee_pkg::OP_WRDI: begin
                        wel_nxt = wel_r & busy_r;
                        st_nxt = ee_pkg::ST_WAIT;
                     end
                     ee_pkg::OP_RDSR: begin
                        tx_nxt = status_v;
                        st_nxt = ee_pkg::ST_DATA;
                     end
                     ee_pkg::OP_READ, ee_pkg::OP_RDID, ee_pkg::OP_RDUID: begin
                        st_nxt = busy_r ? ee_pkg::ST_WAIT : ee_pkg::ST_ADDR;
                     end
                     ee_pkg::OP_WRITE, ee_pkg::OP_WRID: begin
                        st_nxt = (busy_r | ~wel_r) ? ee_pkg::ST_WAIT : ee_pkg::ST_ADDR; // [R19] [R21]
                        mask_nxt = (busy_r | ~wel_r) ? mask_r : 256'h0;
                     end
                     ee_pkg::OP_WRSR: begin
                        st_nxt = (busy_r | ~wel_r | (srwd_r & ~wp_s)) ? ee_pkg::ST_WAIT
                                 : ee_pkg::ST_DATA; // [R7] [R19] [R21]
                     end
                     default: st_nxt = ee_pkg::ST_WAIT; // [R18]
                  endcase
               end
               ee_pkg::ST_ADDR: begin
                  addr_nxt = na_v;
                  acnt_nxt = acnt_r + 2'h1;
                  if (acnt_r == ee_pkg::ADDR_LAST) begin
                     st_nxt = ee_pkg::ST_DATA;
                     if (rd_op) begin
                        tx_nxt = rd_byte(op_r, na_v);
                        addr_nxt = na_v + 18'h1;
                     end
                  end
               end
               ee_pkg::ST_DATA: begin
                  if (rd_op) begin
                     tx_nxt = rd_byte(op_r, addr_r);
                     addr_nxt = addr_r + 18'h1;
                  end else begin
                     got_nxt = 1'b1;
                     srd_nxt = byte_v;
                     mask_nxt[addr_r[7:0]] = 1'b1;
                     addr_nxt = {addr_r[17:8], addr_r[7:0] + 8'h01}; // [R11]
                  end
               end
               default: ;
            endcase
         end
      end else if (fall_e && st_r == ee_pkg::ST_DATA && rd_op) begin
         q_nxt = tx_r[7]; // [R3] [R17]
         tx_nxt = {tx_r[6:0], 1'b0};
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r <= ee_pkg::ST_IDLE;
         op_r <= 8'h00;
         sh_r <= 8'h00;
         bit_r <= 3'h0;
         acnt_r <= 2'h0;
         addr_r <= 18'h0;
         page_r <= 10'h0;
         tx_r <= 8'h00;
         q_r <= 1'b0;
         wel_r <= 1'b0;
         bp_r <= ee_pkg::BP_RST;
         srwd_r <= 1'b0;
         lock_r <= 1'b0;
         got_r <= 1'b0;
         srd_r <= 8'h00;
         busy_r <= 1'b0;
         tmr_r <= 32'h0;
         cp_r <= 8'h00;
         cpon_r <= 1'b0;
         tgt_r <= 1'b0;
         mask_r <= 256'h0;
         hold_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         op_r <= op_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         acnt_r <= acnt_nxt;
         addr_r <= addr_nxt;
         page_r <= page_nxt;
         tx_r <= tx_nxt;
         q_r <= q_nxt;
         wel_r <= wel_nxt;
         bp_r <= bp_nxt;
         srwd_r <= srwd_nxt;
         lock_r <= lock_nxt;
         got_r <= got_nxt;
         srd_r <= srd_nxt;
         busy_r <= busy_nxt;
         tmr_r <= tmr_nxt;
         cp_r <= cp_nxt;
         cpon_r <= cpon_nxt;
         tgt_r <= tgt_nxt;
         mask_r <= mask_nxt;
         hold_r <= hold_nxt;
      end
   end

   // page buffer fill and background copy into the array or the id page
   always_ff @(posedge i_core_clk) begin
      if (wr_byte_e) begin
         pg_buf[addr_r[7:0]] <= byte_v; // [R11]
      end
      if (cpon_r && mask_r[cp_r]) begin
         if (tgt_r) begin
            idpg[cp_r] <= pg_buf[cp_r]; // [R15]
         end else begin
            mem[{page_r, cp_r}] <= pg_buf[cp_r]; // [R14]
         end
      end
   end

   assign o_miso = q_r;
   assign o_miso_oe = ~cs_s & ~hold_r & (st_r == ee_pkg::ST_DATA) & rd_op; // [R4] [R9]
   assign o_standby = cs_s & ~busy_r; // [R5]
   assign o_busy = busy_r;

   a_float_desel: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      cs_s |-> !o_miso_oe) else $error("output driven while deselected"); // [R4]
   a_hold_float: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      hold_r |-> !o_miso_oe && $stable(bit_r)) else $error("pause did not freeze link"); // [R9]
   a_hold_entry: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      $rose(hold_r) |-> !$past(clk_s)) else $error("pause began in clock high phase"); // [R20]
   a_q_on_fall: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      $changed(q_r) |-> $past(fall_e)) else $error("output changed off falling edge"); // [R3]
   a_bad_cmd: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      (st_r == ee_pkg::ST_WAIT) && !cs_s ##1 !cs_s |-> st_r == ee_pkg::ST_WAIT)
      else $error("left wait while selected"); // [R18]
   a_wel_needed: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      $rose(busy_r) |-> $past(wel_r) && !wel_r) else $error("write without enable latch"); // [R19]
   a_busy_len: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      busy_r && tmr_r != 32'h0 |=> busy_r) else $error("write cycle ended early"); // [R12]
   a_standby_idle: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      o_standby |-> cs_s && !busy_r && !cpon_r) else $error("standby during write cycle"); // [R5]
   a_busy_reject: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      busy_r && rise_e && st_r == ee_pkg::ST_CMD && bit_r == ee_pkg::BIT_LAST
      && byte_v == ee_pkg::OP_WRITE |=> st_r == ee_pkg::ST_WAIT) else $error("write accepted while busy"); // [R21]
   a_wp_freeze: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      srwd_r && !wp_s && st_r == ee_pkg::ST_CMD |=> $stable(bp_r)) else $error("protected area changed"); // [R7]
   a_lock_keep: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      lock_r |=> lock_r && !(cpon_r && tgt_r && $rose(cpon_r))) else $error("locked page written"); // [R15]
endmodule : ee_spi_eeprom

/* File: test/ee_spi_master.sv */
/*
 * bus master model for the serial byte memory: mode 0 or 3 framing, msb first, pause.
 * assumes i_core_clk is the 50 ns core clock; serial clock is 8 core cycles a bit.
 */
`timescale 1ns/1ns
module ee_spi_master (
   // core timing
   input wire logic i_core_clk,
   // link pins driven
   output logic o_spi_clk,
   output logic o_cs_n,
   output logic o_mosi,
   output logic o_hold_n,
   output logic o_wp_n,
   // link pins observed
   input wire logic i_miso_wire,
   input wire logic i_miso_oe
);
   logic oe_in_pause;
   // idle clock level: low for mode 0, high for mode 3
   logic clk_idle;

   initial begin
      clk_idle = 1'b0;
      o_spi_clk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      o_hold_n = 1'b1;
      o_wp_n = 1'b1;
      oe_in_pause = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask : tick

   task automatic sel();
      o_spi_clk = clk_idle;
      tick(1);
      o_cs_n = 1'b0;
      tick(4);
   endtask : sel

   // released data line no longer shows the last bit
   task automatic desel();
      o_spi_clk = clk_idle;
      tick(4);
      o_cs_n = 1'b1;
      o_mosi = ~o_mosi;
      tick(8);
   endtask : desel

   task automatic xbyte(input logic [7:0] tx, input int hold_bit, output logic [7:0] rx);
      for (int b = 7; b >= 0; b--) begin
         o_spi_clk = 1'b0;
         o_mosi = tx[b];
         if (b == hold_bit) begin
            o_hold_n = 1'b0;
            tick(4);
            oe_in_pause = i_miso_oe;
            o_spi_clk = 1'b1;
            o_mosi = ~o_mosi;
            tick(4);
            o_spi_clk = 1'b0;
            tick(4);
            o_mosi = tx[b];
            o_hold_n = 1'b1;
         end
         tick(4);
         o_spi_clk = 1'b1;
         rx[b] = i_miso_wire;
         tick(4);
      end
   endtask : xbyte
endmodule : ee_spi_master

/* File: test/test_spi_serial_eeprom_interface.sv */
/*
 * self-checking bench of the serial byte memory front end.
 * assumes ee_spi_master drives the link; short write cycle of 300 core cycles.
 */
`timescale 1ns/1ns
module test_spi_serial_eeprom_interface;
   localparam int P_CYC = 300;
   logic i_core_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic spi_clk, cs_n, mosi, hold_n, wp_n, miso, miso_oe, standby, busy;
   wire miso_wire;
   int n_fail = 0;
   int n_compared = 0;
   logic [7:0] rx[$];

   always #25 i_core_clk = ~i_core_clk;
   assign miso_wire = miso_oe ? miso : 1'bz;

   ee_spi_eeprom #(.P_WRITE_CYC(P_CYC)) uut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
      .i_spi_clk(spi_clk), .i_cs_n(cs_n), .i_mosi(mosi), .i_hold_n(hold_n), .i_wp_n(wp_n),
      .o_miso(miso), .o_miso_oe(miso_oe), .o_standby(standby), .o_busy(busy));
   ee_spi_master m (.i_core_clk(i_core_clk), .o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_mosi(mosi),
      .o_hold_n(hold_n), .o_wp_n(wp_n), .i_miso_wire(miso_wire), .i_miso_oe(miso_oe));

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic frame(input logic [7:0] tx[$], input int hold_byte);
      logic [7:0] r;
      rx = {};
      m.sel();
      foreach (tx[i]) begin
         m.xbyte(tx[i], (i == hold_byte) ? 4 : 8, r);
         rx.push_back(r);
      end
      m.desel();
   endtask : frame

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge i_core_clk);
         n++;
      end
      check("busy end", 8'h00, {7'h00, busy});
      #1;
   endtask : wait_idle

   task automatic t_reset();
      check("standby", 8'h01, {7'h00, standby});
      check("oe idle", 8'h00, {7'h00, miso_oe});
      $display("test reset done");
   endtask : t_reset

   task automatic t_write_read();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'hFF, 8'hA5, 8'h5A}, 99);
      repeat (4) @(posedge i_core_clk);
      check("busy", 8'h01, {7'h00, busy});
      check("standby busy", 8'h00, {7'h00, standby});
      wait_idle();
      frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'hFF, 8'h00}, 99);
      check("rd 1FF", 8'hA5, rx[4]);
      frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'h00, 8'h00}, 4);
      check("rd 100 wrap", 8'h5A, rx[4]);
      check("oe pause", 8'h00, {7'h00, m.oe_in_pause});
      $display("test write read done");
   endtask : t_write_read

   task automatic t_no_wren();
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'h00, 8'h33}, 99);
      repeat (4) @(posedge i_core_clk);
      check("no busy", 8'h00, {7'h00, busy});
      frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'h00, 8'h00}, 99);
      check("rd kept", 8'h5A, rx[4]);
      $display("test no latch done");
   endtask : t_no_wren

   task automatic t_busy();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h02, 8'h00, 8'h11}, 99);
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h02, 8'h00, 8'h22}, 99);
      wait_idle();
      frame({ee_pkg::OP_READ, 8'h00, 8'h02, 8'h00, 8'h00}, 99);
      check("rd busy reject", 8'h11, rx[4]);
      $display("test busy reject done");
   endtask : t_busy

   task automatic t_unknown_uid();
      frame({8'hFF, 8'h03, 8'h00, 8'h01, 8'hFF, 8'h00}, 99);
      check("unknown float", 8'hZZ, rx[5]);
      frame({ee_pkg::OP_RDUID, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 99);
      check("uid 0", ee_pkg::UID_VAL[127:120], rx[4]);
      check("uid 1", ee_pkg::UID_VAL[119:112], rx[5]);
      $display("test unknown and uid done");
   endtask : t_unknown_uid

   task automatic t_protect();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRSR, 8'h0C}, 99);
      wait_idle();
      frame({ee_pkg::OP_RDSR, 8'h00}, 99);
      check("status", 8'h0C, rx[1]);
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'h00, 8'h77}, 99);
      wait_idle();
      frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'h00, 8'h00}, 99);
      check("rd protected", 8'h5A, rx[4]);
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRSR, 8'h84}, 99);
      wait_idle();
      m.o_wp_n = 1'b0;
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRSR, 8'h00}, 99);
      frame({ee_pkg::OP_RDSR, 8'h00}, 99);
      check("status frozen", 8'h86, rx[1]);
      frame({ee_pkg::OP_WRITE, 8'h03, 8'hFF, 8'h00, 8'h44}, 99);
      wait_idle();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h00, 8'h01, 8'h00, 8'h77}, 99);
      wait_idle();
      frame({ee_pkg::OP_READ, 8'h03, 8'hFF, 8'h00, 8'h00}, 99);
      check("rd top quarter", 8'h96, rx[4]);
      frame({ee_pkg::OP_READ, 8'h00, 8'h01, 8'h00, 8'h00}, 99);
      check("rd low quarter", 8'h77, rx[4]);
      $display("test protect done");
   endtask : t_protect

   task automatic t_id_page();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRID, 8'h00, 8'h00, 8'h10, 8'h3C}, 99);
      wait_idle();
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRID, 8'h00, 8'h04, 8'h00, 8'h00}, 99);
      wait_idle();
      frame({ee_pkg::OP_RDID, 8'h00, 8'h04, 8'h00, 8'h00}, 99);
      check("lock status", 8'h01, rx[4]);
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRID, 8'h00, 8'h00, 8'h10, 8'hC3}, 99);
      wait_idle();
      frame({ee_pkg::OP_RDID, 8'h00, 8'h00, 8'h10, 8'h00}, 99);
      check("id kept", 8'h3C, rx[4]);
      $display("test id page done");
   endtask : t_id_page

   task automatic t_mode3();
      m.clk_idle = 1'b1;
      frame({ee_pkg::OP_WREN}, 99);
      frame({ee_pkg::OP_WRITE, 8'h03, 8'hFF, 8'h00, 8'h96}, 99);
      wait_idle();
      frame({ee_pkg::OP_READ, 8'h03, 8'hFF, 8'h00, 8'h00}, 99);
      check("rd mode 3", 8'h96, rx[4]);
      m.clk_idle = 1'b0;
      $display("test mode 3 done");
   endtask : t_mode3

   // select held low across a reset must not open a frame
   task automatic t_reset_low_select();
      logic [7:0] r;
      m.o_cs_n = 1'b0;
      i_resetn = 1'b0;
      m.tick(3);
      check("oe in reset", 8'h00, {7'h00, miso_oe});
      i_resetn = 1'b1;
      m.tick(6);
      m.xbyte(ee_pkg::OP_WREN, 99, r);
      m.desel();
      frame({ee_pkg::OP_RDSR, 8'h00}, 99);
      check("no early command", 8'h00, rx[1]);
      $display("test reset with select low done");
   endtask : t_reset_low_select

   task automatic final_report();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : final_report

   initial begin
      // about three times the expected run of some 13000 core cycles
      #2000000;
      n_fail++;
      final_report();
   end

   initial begin
      repeat (12) @(posedge i_core_clk);
      #1 i_resetn = 1'b1;
      repeat (6) @(posedge i_core_clk);
      #1;
      t_reset();
      t_write_read();
      t_no_wren();
      t_busy();
      t_unknown_uid();
      t_id_page();
      t_mode3();
      t_protect();
      t_reset_low_select();
      final_report();
   end
endmodule : test_spi_serial_eeprom_interface
